// >>> hdl/sipo_latch_defines.svh
// Constants for the serial-to-parallel latch block.
// Assumes inclusion by bare name from the design files.
`ifndef SIPO_LATCH_DEFINES_SVH
`define SIPO_LATCH_DEFINES_SVH
`define SIPO_WIDTH 8
`define SIPO_ZERO 8'h00
`define SIPO_BIT_ZERO 1'h0
`define SIPO_BIT_ONE 1'h1
`define SIPO_SYNC_RST 2'h0
`endif

// >>> hdl/sipo_latch_pkg.sv
// Types shared by the serial-to-parallel latch block.
// Assumes the defines header is on the include path.
`include "sipo_latch_defines.svh"
package sipo_latch_pkg;
  typedef logic [`SIPO_WIDTH-1:0] stage_word_t;
  typedef enum logic {out_float, out_drive} out_mode_t;
endpackage

// >>> hdl/stage_xfer_if.sv
// Carrier for the shift-stage word passed from the link domain to the core.
// Assumes a single producer (shift stage) and a single consumer (top).
`timescale 1ns/1ps
interface stage_xfer_if;
  import sipo_latch_pkg::*;
  stage_word_t stages;
  logic cascade;
  modport producer (output stages, output cascade);
  modport consumer (input stages, input cascade);
endinterface

// >>> hdl/shift_stage.sv
// Eight-stage serial shift chain clocked by the link shift clock.
// Assumes clear is asynchronous and active low.
`timescale 1ns/1ps
`include "sipo_latch_defines.svh"
module shift_stage #(
  parameter int WIDTH = `SIPO_WIDTH
) (
  // Link side
  input wire logic shift_clock,
  input wire logic shift_clear_n,
  input wire logic serial_data_in,
  // Core side
  stage_xfer_if.producer xfer
);
  import sipo_latch_pkg::*;
  logic [WIDTH-1:0] chain_ff;
  logic [WIDTH-1:0] nxt_chain;
  assign nxt_chain = {chain_ff[WIDTH-2:0], serial_data_in};
  // Clear overrides any shifting
  always_ff @(posedge shift_clock or negedge shift_clear_n) begin
    if (!shift_clear_n) begin
      chain_ff <= '0;
    end else begin
      chain_ff <= nxt_chain;
    end
  end
  assign xfer.stages = chain_ff;
  assign xfer.cascade = chain_ff[WIDTH-1];
endmodule

// >>> hdl/store_stage.sv
// Storage register loaded on the rising storage clock.
// Assumes the shift word has settled before each storage edge.
`timescale 1ns/1ps
`include "sipo_latch_defines.svh"
module store_stage #(
  parameter int WIDTH = `SIPO_WIDTH
) (
  // Clock and reset
  input wire logic storage_clock,
  input wire logic rst_b_in,
  // Data
  input wire logic [WIDTH-1:0] stages_in,
  output logic [WIDTH-1:0] held_out
);
  logic [WIDTH-1:0] held_ff;
  // Non-blocking capture takes the pre-edge word when clocks are tied
  always_ff @(posedge storage_clock or negedge rst_b_in) begin
    if (!rst_b_in) begin
      held_ff <= '0;
    end else begin
      held_ff <= stages_in;
    end
  end
  assign held_out = held_ff;
endmodule

// >>> hdl/serial_to_parallel_latch.sv
// Top of the latch: the shift chain runs on shift_clock and the storage on
// store_pulse_in; the pin side runs on sys_clk_in behind synchronisers.
// Assumes shift_clock runs far slower than sys_clk_in (125 ns against 5 ns).
`timescale 1ns/1ps
`include "sipo_latch_defines.svh"
module serial_to_parallel_latch #(
  parameter int WIDTH = `SIPO_WIDTH
) (
  // System clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Link side
  input wire logic shift_clock,
  input wire logic shift_clear_n,
  input wire logic serial_data_in,
  input wire logic store_pulse_in,
  input wire logic output_enable_b_in,
  // Parallel outputs, two signals per pin
  output sipo_latch_pkg::stage_word_t parallel_outputs,
  output sipo_latch_pkg::stage_word_t parallel_oe_out,
  // Cascade
  output logic cascade_serial_out
);
  import sipo_latch_pkg::*;

  stage_xfer_if xfer ();
  stage_word_t held_word;

  shift_stage #(.WIDTH(WIDTH)) u_shift (
    .shift_clock(shift_clock),
    .shift_clear_n(shift_clear_n),
    .serial_data_in(serial_data_in),
    .xfer(xfer)
  );

  // Storage clock is its own input; in the tied case it equals shift_clock
  store_stage #(.WIDTH(WIDTH)) u_store (
    .storage_clock(store_pulse_in),
    .rst_b_in(rst_b_in),
    .stages_in(xfer.stages),
    .held_out(held_word)
  );

  // Each store edge flips this flag; the core reloads when it sees a flip.
  // Sampling the word bit by bit instead could tear it mid-change.
  logic store_tgl_ff;
  wire logic nxt_store_tgl;
  assign nxt_store_tgl = ~store_tgl_ff;

  always_ff @(posedge store_pulse_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      store_tgl_ff <= `SIPO_BIT_ZERO;
    end else begin
      store_tgl_ff <= nxt_store_tgl;
    end
  end

  // Reset asserts at once but leaves only on a system clock edge
  logic rst_meta_ff;
  wire logic nxt_rst_meta;
  assign nxt_rst_meta = `SIPO_BIT_ONE;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_ff <= `SIPO_BIT_ZERO;
    end else begin
      rst_meta_ff <= nxt_rst_meta;
    end
  end

  logic rst_sync_ff;
  wire logic nxt_rst_sync;
  assign nxt_rst_sync = rst_meta_ff;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_ff <= `SIPO_BIT_ZERO;
    end else begin
      rst_sync_ff <= nxt_rst_sync;
    end
  end

  wire logic core_rst_b;
  assign core_rst_b = rst_sync_ff;

  // Flag crossing: the held word is read only once the flag has passed
  // two flops, so it has stood still for at least two cycles by then
  logic tgl_meta_ff;
  wire logic nxt_tgl_meta;
  assign nxt_tgl_meta = store_tgl_ff;

  always_ff @(posedge sys_clk_in or negedge core_rst_b) begin
    if (!core_rst_b) begin
      tgl_meta_ff <= `SIPO_BIT_ZERO;
    end else begin
      tgl_meta_ff <= nxt_tgl_meta;
    end
  end

  logic tgl_sync_ff;
  wire logic nxt_tgl_sync;
  assign nxt_tgl_sync = tgl_meta_ff;

  always_ff @(posedge sys_clk_in or negedge core_rst_b) begin
    if (!core_rst_b) begin
      tgl_sync_ff <= `SIPO_BIT_ZERO;
    end else begin
      tgl_sync_ff <= nxt_tgl_sync;
    end
  end

  logic tgl_seen_ff;
  wire logic nxt_tgl_seen;
  assign nxt_tgl_seen = tgl_sync_ff;

  always_ff @(posedge sys_clk_in or negedge core_rst_b) begin
    if (!core_rst_b) begin
      tgl_seen_ff <= `SIPO_BIT_ZERO;
    end else begin
      tgl_seen_ff <= nxt_tgl_seen;
    end
  end

  wire logic load_word;
  assign load_word = tgl_sync_ff ^ tgl_seen_ff;

  // Cascade is a single bit, so a plain two-flop crossing is enough
  logic casc_meta_ff;
  wire logic nxt_casc_meta;
  assign nxt_casc_meta = xfer.cascade;

  always_ff @(posedge sys_clk_in or negedge core_rst_b) begin
    if (!core_rst_b) begin
      casc_meta_ff <= `SIPO_BIT_ZERO;
    end else begin
      casc_meta_ff <= nxt_casc_meta;
    end
  end

  logic casc_sync_ff;
  wire logic nxt_casc_sync;
  assign nxt_casc_sync = casc_meta_ff;

  always_ff @(posedge sys_clk_in or negedge core_rst_b) begin
    if (!core_rst_b) begin
      casc_sync_ff <= `SIPO_BIT_ZERO;
    end else begin
      casc_sync_ff <= nxt_casc_sync;
    end
  end

  // Enable pin crossing; resets to the floating level
  logic oe_meta_ff;
  wire logic nxt_oe_meta;
  assign nxt_oe_meta = output_enable_b_in;

  always_ff @(posedge sys_clk_in or negedge core_rst_b) begin
    if (!core_rst_b) begin
      oe_meta_ff <= `SIPO_BIT_ONE;
    end else begin
      oe_meta_ff <= nxt_oe_meta;
    end
  end

  logic oe_sync_ff;
  wire logic nxt_oe_sync;
  assign nxt_oe_sync = oe_meta_ff;

  always_ff @(posedge sys_clk_in or negedge core_rst_b) begin
    if (!core_rst_b) begin
      oe_sync_ff <= `SIPO_BIT_ONE;
    end else begin
      oe_sync_ff <= nxt_oe_sync;
    end
  end

  // Enable decode reaches only the drive flops, never the data path
  out_mode_t mode;
  wire logic pin_drive;
  assign mode = oe_sync_ff ? out_float : out_drive;
  assign pin_drive = (mode == out_drive);

  // One cell per pin: the stored bit and that pin's drive enable
  wire logic [WIDTH-1:0] pin_data;
  wire logic [WIDTH-1:0] pin_en;
  for (genvar pin = 0; pin < WIDTH; pin++) begin : g_pin
    logic bit_ff;
    logic en_ff;
    wire logic nxt_bit;
    assign nxt_bit = load_word ? held_word[pin] : bit_ff;

    always_ff @(posedge sys_clk_in or negedge core_rst_b) begin
      if (!core_rst_b) begin
        bit_ff <= `SIPO_BIT_ZERO;
      end else begin
        bit_ff <= nxt_bit;
      end
    end

    always_ff @(posedge sys_clk_in or negedge core_rst_b) begin
      if (!core_rst_b) begin
        en_ff <= `SIPO_BIT_ZERO;
      end else begin
        en_ff <= pin_drive;
      end
    end

    assign pin_data[pin] = bit_ff;
    assign pin_en[pin] = en_ff;
  end

  // Cascade keeps driving whatever the enable does
  logic cascade_ff;
  wire logic nxt_cascade;
  assign nxt_cascade = casc_sync_ff;

  always_ff @(posedge sys_clk_in or negedge core_rst_b) begin
    if (!core_rst_b) begin
      cascade_ff <= `SIPO_BIT_ZERO;
    end else begin
      cascade_ff <= nxt_cascade;
    end
  end

  assign parallel_outputs = pin_data;
  assign parallel_oe_out = pin_en;
  assign cascade_serial_out = cascade_ff;
endmodule

// >>> tb/sipo_latch_asserts.sv
// Pin checks for the latch, system clock view.
// Assumes only the top ports are visible.
`timescale 1ns/1ps
module sipo_latch_asserts (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Controls
  input wire logic shift_clock,
  input wire logic shift_clear_n,
  input wire logic store_pulse_in,
  input wire logic output_enable_b_in,
  // Outputs
  input wire sipo_latch_pkg::stage_word_t parallel_outputs,
  input wire sipo_latch_pkg::stage_word_t parallel_oe_out,
  input wire logic cascade_serial_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  AST_OE_SAME: assert property (parallel_oe_out == 8'h00 || parallel_oe_out == 8'hff)
    else $error("oe split");
  AST_OE_ON: assert property ($fell(output_enable_b_in) |-> ##[2:4] parallel_oe_out == 8'hff)
    else $error("oe on");
  AST_OE_OFF: assert property ($rose(output_enable_b_in) |-> ##[2:4] parallel_oe_out == 8'h00)
    else $error("oe off");
  AST_OE_HOLD: assert property (output_enable_b_in [*6] |-> parallel_oe_out == 8'h00)
    else $error("float");
  AST_OE_DRV: assert property (!output_enable_b_in [*6] |-> parallel_oe_out == 8'hff)
    else $error("drive");
  AST_CLR: assert property ($fell(shift_clear_n) |-> ##[2:4] !cascade_serial_out)
    else $error("clear");
  AST_CLR_HOLD: assert property (!shift_clear_n [*6] |-> !cascade_serial_out)
    else $error("clear hold");
  AST_STORE: assert property ($stable(store_pulse_in) [*6] |-> $stable(parallel_outputs))
    else $error("store");
  AST_CASC: assert property (($stable(shift_clock) && shift_clear_n) [*6] |-> $stable(cascade_serial_out))
    else $error("casc");
endmodule
bind serial_to_parallel_latch sipo_latch_asserts u_chk (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
  .shift_clock(shift_clock), .shift_clear_n(shift_clear_n), .store_pulse_in(store_pulse_in),
  .output_enable_b_in(output_enable_b_in), .parallel_outputs(parallel_outputs),
  .parallel_oe_out(parallel_oe_out), .cascade_serial_out(cascade_serial_out));

// >>> tb/link_host.sv
// Controller model clocking serial words in.
// Assumes calls come between frames only.
`timescale 1ns/1ps
module link_host (
  // Link pins
  output logic shift_clock,
  output logic serial_data_in
);
  initial begin
    shift_clock = 1'h0;
    serial_data_in = 1'h0;
  end
  // First bit out ends in stage eight
  task automatic send(input logic [7:0] w);
    #1.3;
    for (int i = 7; i >= 0; i--) begin
      serial_data_in = w[i];
      #62.5 shift_clock = 1'h1;
      #62.5 shift_clock = 1'h0;
    end
    // Released line shows no stale bit
    serial_data_in = ~serial_data_in;
  endtask
endmodule

// >>> tb/tb.sv
// Bench for the serial-to-parallel latch.
// Assumes link_host drives the link pins.
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; $display("MISMATCH %0t %h %h", $time, a, e); end end
module tb;
  import sipo_latch_pkg::*;
  logic sys_clk_in = 1'h0, rst_b_in = 1'h0, shift_clear_n = 1'h1, store_r = 1'h0, oe_b = 1'h1, tie = 1'h0;
  wire logic shift_clock, serial_data_in;
  wire logic store = tie ? shift_clock : store_r;
  stage_word_t q, q_oe;
  logic casc;
  int bad_count = 0, checked = 0;
  always #2.5 sys_clk_in = ~sys_clk_in;
  link_host host (.shift_clock(shift_clock), .serial_data_in(serial_data_in));
  serial_to_parallel_latch DUT (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .shift_clock(shift_clock),
    .shift_clear_n(shift_clear_n), .serial_data_in(serial_data_in), .store_pulse_in(store),
    .output_enable_b_in(oe_b), .parallel_outputs(q), .parallel_oe_out(q_oe), .cascade_serial_out(casc));
  task automatic settle(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  task automatic pulse_store();
    settle(1);
    store_r = 1'h1;
    settle(26);
    store_r = 1'h0;
    settle(26);
  endtask
  task automatic t_load();
    host.send(8'ha5);
    pulse_store();
    `CHK(q, 8'ha5)
    `CHK(casc, 1'h1)
  endtask
  task automatic t_oe();
    settle(1);
    oe_b = 1'h0;
    settle(6);
    `CHK(q_oe, 8'hff)
    `CHK(q, 8'ha5)
    oe_b = 1'h1;
    settle(6);
    `CHK(q_oe, 8'h00)
    `CHK(q, 8'ha5)
  endtask
  task automatic t_clear();
    settle(1);
    shift_clear_n = 1'h0;
    settle(30);
    `CHK(casc, 1'h0)
    `CHK(q, 8'ha5)
    host.send(8'hff);
    settle(1);
    shift_clear_n = 1'h1;
    pulse_store();
    `CHK(q, 8'h00)
  endtask
  // Tied clocks: storage sees the word from before the last edge
  task automatic t_tied();
    tie = 1'h1;
    host.send(8'h3c);
    settle(30);
    `CHK(q, 8'h1e)
    `CHK(casc, 1'h0)
    tie = 1'h0;
  endtask
  task automatic end_sim();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    settle(3);
    rst_b_in = 1'h1;
    `CHK(q_oe, 8'h00)
    t_load();
    t_oe();
    t_clear();
    t_tied();
    end_sim();
  end
endmodule
